// File: common/cpe_defines.svh
// offsets, field positions, reset values and maps for the pipeline block
`ifndef CPE_DEFINES_SVH
`define CPE_DEFINES_SVH
`define CPE_SEL_FAULT_ADDR 3'h3
`define CPE_SEL_FAULT_STAT 3'h5
`define CPE_SEL_FP_FLAG 3'h7
`define CPE_FAULT_ADDR_RST 32'h0000_0000
`define CPE_RESET_PC 32'h0000_0000
`define CPE_EXC_VECTOR 32'h0000_0020
`define CPE_WORD_STEP 32'h0000_0004
`define CPE_CODE_HI 4
`define CPE_CODE_LO 0
`define CPE_DET_WORD 11
`define CPE_DET_STORE 10
`define CPE_DET_REG_HI 9
`define CPE_DET_REG_LO 5
`define CPE_FP_BAD_OP 4
`define CPE_FP_ZERO_DIV 3
`define CPE_FP_TOO_LARGE 2
`define CPE_FP_TOO_SMALL 1
`define CPE_FP_DENORM 0
`define CPE_PF_DEPTH 2'h2
`define CPE_LMP_BASE 32'h0000_0000
`define CPE_LMP_MASK 32'hFFFF_0000
`define CPE_CLP_BASE 32'h8000_0000
`define CPE_CLP_MASK 32'hF000_0000
`endif

// File: common/cpe_pkg.sv
// types shared by the pipeline and exception block
package cpe_pkg;
    typedef enum logic [1:0] {
        CPE_SZ_BYTE = 2'h0,
        CPE_SZ_HALF = 2'h1,
        CPE_SZ_WORD = 2'h2
    } cpe_size_e;
    typedef enum logic [4:0] {
        CPE_EC_NONE = 5'h00,
        CPE_EC_UNALIGNED = 5'h01,
        CPE_EC_ILLEGAL = 5'h02,
        CPE_EC_IBUS = 5'h03,
        CPE_EC_DBUS = 5'h04,
        CPE_EC_DIV0 = 5'h05,
        CPE_EC_FPU = 5'h06
    } cpe_cause_e;
endpackage

// File: logic/cpe_core_pipe.sv
// three-stage pipeline control with exception and fp flag registers
`timescale 1ns/100ps
`include "cpe_defines.svh"
module cpe_core_pipe (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] imem_rdata,
    input wire logic imem_ack,
    output logic imem_req,
    output logic [31:0] imem_addr,
    output logic dec_valid,
    output logic [31:0] dec_pc,
    output logic ex_valid,
    output logic [31:0] ex_instr,
    output logic [31:0] ex_pc,
    input wire logic ex_busy,
    input wire logic br_taken,
    input wire logic br_delay,
    input wire logic [31:0] br_target,
    input wire logic dreq,
    input wire logic [31:0] dreq_addr,
    input wire logic [1:0] dreq_size,
    input wire logic dreq_store,
    input wire logic [4:0] dreq_reg,
    input wire logic trap_unaligned,
    output logic [2:0] dport_req,
    output logic [2:0] dport_abort,
    output logic [31:0] dport_addr,
    output logic [3:0] dport_be,
    output logic dport_we,
    input wire logic dbus_err,
    input wire logic exc_illegal,
    input wire logic exc_ibus,
    input wire logic exc_div0,
    input wire logic exc_fpu,
    input wire logic [4:0] fp_raise,
    input wire logic spec_rd,
    input wire logic spec_wr,
    input wire logic [2:0] special_sel,
    input wire logic [31:0] spec_wdata,
    output logic [31:0] spec_rdata,
    output logic exc_taken,
    output logic [31:0] exc_ret_pc
);
    logic dec_valid_reg, dec_valid_next;
    logic [31:0] dec_instr_reg, dec_instr_next;
    logic [31:0] dec_pc_reg, dec_pc_next;
    logic ex_valid_reg, ex_valid_next;
    logic [31:0] ex_instr_reg, ex_instr_next;
    logic [31:0] ex_pc_reg, ex_pc_next;
    logic [31:0] next_pc_reg, next_pc_next;
    logic imem_req_reg, imem_req_next;
    logic [31:0] pf_instr_reg [2];
    logic [31:0] pf_instr_next [2];
    logic [31:0] pf_pc_reg [2];
    logic [31:0] pf_pc_next [2];
    logic [1:0] pf_cnt_reg, pf_cnt_next;
    logic pf_rd_reg, pf_rd_next;
    logic pf_wr_reg, pf_wr_next;
    logic [2:0] dport_req_reg, dport_req_next;
    logic [2:0] dport_abort_reg, dport_abort_next;
    logic [31:0] dport_addr_reg, dport_addr_next;
    logic [3:0] dport_be_reg, dport_be_next;
    logic dport_we_reg, dport_we_next;
    logic [31:0] fault_addr_reg, fault_addr_next;
    logic [4:0] cause_code_reg, cause_code_next;
    logic [6:0] cause_detail_reg, cause_detail_next;
    logic [4:0] fp_flag_reg, fp_flag_next;
    logic [31:0] spec_rdata_reg, spec_rdata_next;
    logic exc_taken_reg, exc_taken_next;
    logic [31:0] exc_ret_pc_reg, exc_ret_pc_next;
    logic misaligned, unal_exc, exc_take, br_plain, br_slot;
    logic [2:0] port_hit;

    // shared exception qualifiers
    always_comb begin
        misaligned = 1'b0;
        if (dreq_size == cpe_pkg::CPE_SZ_WORD) begin
            misaligned = (dreq_addr[1:0] != 2'h0);
        end else if (dreq_size == cpe_pkg::CPE_SZ_HALF) begin
            misaligned = dreq_addr[0];
        end
        unal_exc = dreq & trap_unaligned & misaligned;
        exc_take = unal_exc | dbus_err | exc_illegal | exc_ibus |
                   exc_div0 | exc_fpu;
        br_plain = br_taken & ex_valid_reg & ~br_delay;
        br_slot = br_taken & ex_valid_reg & br_delay;
    end

    // pipeline stages and prefetch buffer
    always_comb begin
        dec_valid_next = dec_valid_reg;
        dec_instr_next = dec_instr_reg;
        dec_pc_next = dec_pc_reg;
        ex_valid_next = ex_valid_reg;
        ex_instr_next = ex_instr_reg;
        ex_pc_next = ex_pc_reg;
        next_pc_next = next_pc_reg;
        pf_instr_next = pf_instr_reg;
        pf_pc_next = pf_pc_reg;
        pf_cnt_next = pf_cnt_reg;
        pf_rd_next = pf_rd_reg;
        pf_wr_next = pf_wr_reg;
        if (exc_take) begin
            // the faulting execute instruction is dropped
            dec_valid_next = 1'b0;
            ex_valid_next = 1'b0;
            pf_cnt_next = 2'h0;
            pf_rd_next = 1'b0;
            pf_wr_next = 1'b0;
            next_pc_next = `CPE_EXC_VECTOR;
        end else if (br_plain) begin
            dec_valid_next = 1'b0;
            ex_valid_next = 1'b0;
            pf_cnt_next = 2'h0;
            pf_rd_next = 1'b0;
            pf_wr_next = 1'b0;
            next_pc_next = {br_target[31:2], 2'h0};
        end else if (br_slot) begin
            // buffer holds wrong-path words past the slot, so drop it too
            ex_valid_next = dec_valid_reg;
            ex_instr_next = dec_instr_reg;
            ex_pc_next = dec_pc_reg;
            dec_valid_next = 1'b0;
            pf_cnt_next = 2'h0;
            pf_rd_next = 1'b0;
            pf_wr_next = 1'b0;
            next_pc_next = {br_target[31:2], 2'h0};
        end else if (ex_busy) begin
            // stages hold; arriving words park in the buffer
            if (imem_ack) begin
                pf_instr_next[pf_wr_reg] = imem_rdata;
                pf_pc_next[pf_wr_reg] = next_pc_reg;
                pf_wr_next = ~pf_wr_reg;
                pf_cnt_next = pf_cnt_reg + 2'h1;
                next_pc_next = next_pc_reg + `CPE_WORD_STEP;
            end
        end else begin
            ex_valid_next = dec_valid_reg;
            ex_instr_next = dec_instr_reg;
            ex_pc_next = dec_pc_reg;
            // fetch is the memory cycle itself, so refill costs two cycles
            if (pf_cnt_reg != 2'h0) begin
                dec_valid_next = 1'b1;
                dec_instr_next = pf_instr_reg[pf_rd_reg];
                dec_pc_next = pf_pc_reg[pf_rd_reg];
                pf_rd_next = ~pf_rd_reg;
                pf_cnt_next = pf_cnt_reg - 2'h1;
                if (imem_ack) begin
                    pf_instr_next[pf_wr_reg] = imem_rdata;
                    pf_pc_next[pf_wr_reg] = next_pc_reg;
                    pf_wr_next = ~pf_wr_reg;
                    pf_cnt_next = pf_cnt_reg;
                end
            end else begin
                dec_valid_next = imem_ack;
                dec_instr_next = imem_rdata;
                dec_pc_next = next_pc_reg;
            end
            if (imem_ack) begin
                next_pc_next = next_pc_reg + `CPE_WORD_STEP;
            end
        end
        // a request is only made while a slot is sure to be free
        imem_req_next = (pf_cnt_next < `CPE_PF_DEPTH);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_valid_reg <= 1'b0;
            dec_instr_reg <= 32'h0000_0000;
            dec_pc_reg <= `CPE_RESET_PC;
            ex_valid_reg <= 1'b0;
            ex_instr_reg <= 32'h0000_0000;
            ex_pc_reg <= `CPE_RESET_PC;
            next_pc_reg <= `CPE_RESET_PC;
            imem_req_reg <= 1'b0;
            pf_instr_reg <= '{default: 32'h0000_0000};
            pf_pc_reg <= '{default: 32'h0000_0000};
            pf_cnt_reg <= 2'h0;
            pf_rd_reg <= 1'b0;
            pf_wr_reg <= 1'b0;
        end else begin
            dec_valid_reg <= dec_valid_next;
            dec_instr_reg <= dec_instr_next;
            dec_pc_reg <= dec_pc_next;
            ex_valid_reg <= ex_valid_next;
            ex_instr_reg <= ex_instr_next;
            ex_pc_reg <= ex_pc_next;
            next_pc_reg <= next_pc_next;
            imem_req_reg <= imem_req_next;
            pf_instr_reg <= pf_instr_next;
            pf_pc_reg <= pf_pc_next;
            pf_cnt_reg <= pf_cnt_next;
            pf_rd_reg <= pf_rd_next;
            pf_wr_reg <= pf_wr_next;
        end
    end

    // data ports: speculative issue on all three, losers aborted next
    always_comb begin
        // maps assumed disjoint, so exactly one port hits
        port_hit[0] = ((dport_addr_reg & `CPE_LMP_MASK) ==
                       `CPE_LMP_BASE);
        port_hit[2] = ((dport_addr_reg & `CPE_CLP_MASK) ==
                       `CPE_CLP_BASE);
        port_hit[1] = ~port_hit[0] & ~port_hit[2];
        dport_abort_next = dport_req_reg & ~port_hit;
        dport_req_next = (dreq & ~exc_take) ? 3'h7 : 3'h0;
        dport_addr_next = dreq ? dreq_addr : dport_addr_reg;
        dport_we_next = dreq & dreq_store;
        // big-endian lanes: byte 0 rides on the top lane
        case (dreq_size)
            cpe_pkg::CPE_SZ_WORD: dport_be_next = 4'hF;
            cpe_pkg::CPE_SZ_HALF: begin
                dport_be_next = dreq_addr[1] ? 4'h3 : 4'hC;
            end
            default: dport_be_next = 4'h8 >> dreq_addr[1:0];
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dport_req_reg <= 3'h0;
            dport_abort_reg <= 3'h0;
            dport_addr_reg <= 32'h0000_0000;
            dport_be_reg <= 4'h0;
            dport_we_reg <= 1'b0;
        end else begin
            dport_req_reg <= dport_req_next;
            dport_abort_reg <= dport_abort_next;
            dport_addr_reg <= dport_addr_next;
            dport_be_reg <= dport_be_next;
            dport_we_reg <= dport_we_next;
        end
    end

    // exception capture, fp flags and special register reads
    always_comb begin
        fault_addr_next = fault_addr_reg;
        cause_code_next = cause_code_reg;
        cause_detail_next = cause_detail_reg;
        exc_taken_next = exc_take;
        exc_ret_pc_next = exc_take ? dec_pc_reg : exc_ret_pc_reg;
        if (unal_exc) begin
            fault_addr_next = dreq_addr;
            cause_code_next = cpe_pkg::CPE_EC_UNALIGNED;
            cause_detail_next = {dreq_size == cpe_pkg::CPE_SZ_WORD,
                                 dreq_store, dreq_reg};
        end else if (dbus_err) begin
            fault_addr_next = dport_addr_reg;
            cause_code_next = cpe_pkg::CPE_EC_DBUS;
            cause_detail_next = 7'h00;
        end else if (exc_illegal) begin
            cause_code_next = cpe_pkg::CPE_EC_ILLEGAL;
            cause_detail_next = 7'h00;
        end else if (exc_ibus) begin
            cause_code_next = cpe_pkg::CPE_EC_IBUS;
            cause_detail_next = 7'h00;
        end else if (exc_div0) begin
            cause_code_next = cpe_pkg::CPE_EC_DIV0;
            cause_detail_next = 7'h00;
        end else if (exc_fpu) begin
            cause_code_next = cpe_pkg::CPE_EC_FPU;
            cause_detail_next = 7'h00;
        end
        // raised flags win over a software write in the same cycle
        fp_flag_next = fp_flag_reg;
        if (spec_wr && special_sel == `CPE_SEL_FP_FLAG) begin
            fp_flag_next = spec_wdata[4:0];
        end
        fp_flag_next = fp_flag_next | fp_raise;
        spec_rdata_next = spec_rdata_reg;
        if (spec_rd) begin
            case (special_sel)
                `CPE_SEL_FAULT_ADDR: spec_rdata_next = fault_addr_reg;
                `CPE_SEL_FAULT_STAT: begin
                    spec_rdata_next = {20'h0_0000, cause_detail_reg,
                                       cause_code_reg};
                end
                `CPE_SEL_FP_FLAG: spec_rdata_next = {27'h000_0000,
                                                     fp_flag_reg};
                default: spec_rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_addr_reg <= `CPE_FAULT_ADDR_RST;
            cause_code_reg <= cpe_pkg::CPE_EC_NONE;
            cause_detail_reg <= 7'h00;
            fp_flag_reg <= 5'h00;
            spec_rdata_reg <= 32'h0000_0000;
            exc_taken_reg <= 1'b0;
            exc_ret_pc_reg <= 32'h0000_0000;
        end else begin
            fault_addr_reg <= fault_addr_next;
            cause_code_reg <= cause_code_next;
            cause_detail_reg <= cause_detail_next;
            fp_flag_reg <= fp_flag_next;
            spec_rdata_reg <= spec_rdata_next;
            exc_taken_reg <= exc_taken_next;
            exc_ret_pc_reg <= exc_ret_pc_next;
        end
    end

    assign imem_req = imem_req_reg;
    assign imem_addr = next_pc_reg;
    assign dec_valid = dec_valid_reg;
    assign dec_pc = dec_pc_reg;
    assign ex_valid = ex_valid_reg;
    assign ex_instr = ex_instr_reg;
    assign ex_pc = ex_pc_reg;
    assign dport_req = dport_req_reg;
    assign dport_abort = dport_abort_reg;
    assign dport_addr = dport_addr_reg;
    assign dport_be = dport_be_reg;
    assign dport_we = dport_we_reg;
    assign spec_rdata = spec_rdata_reg;
    assign exc_taken = exc_taken_reg;
    assign exc_ret_pc = exc_ret_pc_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_unal_addr: assert property (unal_exc |=> fault_addr_reg ==
        $past(dreq_addr) && cause_code_reg == 5'h01)
        else $error("unaligned fault address or cause wrong");
    a_dbus_cause: assert property (dbus_err && !unal_exc |=>
        cause_code_reg == 5'h04 && fault_addr_reg ==
        $past(dport_addr_reg))
        else $error("data bus error capture wrong");
    a_unal_detail: assert property (unal_exc |=> cause_detail_reg ==
        {$past(dreq_size) == 2'h2, $past(dreq_store),
        $past(dreq_reg)})
        else $error("unaligned detail wrong");
    a_read_fault: assert property (spec_rd && special_sel == 3'h3 |=>
        spec_rdata == $past(fault_addr_reg))
        else $error("fault address read wrong");
    a_read_status: assert property (spec_rd && special_sel == 3'h5 |=>
        spec_rdata[4:0] == $past(cause_code_reg) &&
        spec_rdata[31:12] == 20'h0_0000)
        else $error("fault status read wrong");
    a_fp_sticky: assert property (!spec_wr ##0 fp_flag_reg[2] |=>
        fp_flag_reg[2])
        else $error("fp flag lost without a write");
    a_fp_write: assert property (spec_wr && special_sel == 3'h7 |=>
        fp_flag_reg == ($past(spec_wdata[4:0]) | $past(fp_raise)))
        else $error("fp flag write wrong");
    a_stall_hold: assert property (ex_busy && !exc_take && !br_taken
        |=> $stable(dec_pc_reg) && $stable(ex_pc_reg))
        else $error("decode moved during stall");
    a_flow_step: assert property (!ex_busy && !exc_take && !br_taken
        && dec_valid_reg |=> ex_valid_reg &&
        ex_pc_reg == $past(dec_pc_reg))
        else $error("pipeline did not advance");
    a_plain_flush: assert property (br_plain && !exc_take |=>
        !ex_valid_reg && !dec_valid_reg && pf_cnt_reg == 2'h0
        && imem_addr == {$past(br_target[31:2]), 2'h0})
        else $error("plain branch flush wrong");
    a_slot_keep: assert property (br_slot && !exc_take |=>
        ex_valid_reg == $past(dec_valid_reg) &&
        ex_pc_reg == $past(dec_pc_reg) && !dec_valid_reg)
        else $error("delay slot not kept");
    a_exc_vector: assert property (exc_take |=> exc_taken &&
        imem_addr == 32'h0000_0020 && !ex_valid_reg &&
        exc_ret_pc == $past(dec_pc_reg))
        else $error("exception entry wrong");
    a_port_abort: assert property (dport_req_reg == 3'h7 |=>
        dport_abort == ($past(dport_req_reg) & ~$past(port_hit))
        && $countones(dport_abort) == 2)
        else $error("losing ports not aborted");
    a_pf_bound: assert property (pf_cnt_reg <= 2'h2)
        else $error("prefetch buffer overflow");

    c_stall_fill: cover property (ex_busy && imem_ack ##1
        ex_busy && imem_ack);
    c_slot_branch: cover property (br_slot && dec_valid_reg);
    c_unal_trap: cover property (unal_exc && dreq_store);
    c_pf_drain: cover property (!ex_busy && pf_cnt_reg == 2'h2);
endmodule

// File: verification/cpe_mem_model.sv
// instruction memory and data-side fault source for the pipeline bench
`timescale 1ns/100ps
module cpe_mem_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic err_inject,
    input wire logic imem_req,
    input wire logic [31:0] imem_addr,
    output logic imem_ack,
    output logic [31:0] imem_rdata,
    input wire logic [2:0] dport_req,
    input wire logic [31:0] dport_addr,
    output logic dbus_err
);
    logic phase = 1'b0;
    logic hit;
    logic periph;
    // one word per aligned address; slow mode answers every other cycle
    assign hit = imem_req && (!slow || phase);
    // peripheral map is what the local and cache-link maps leave over
    assign periph = dport_addr[31:16] != 16'h0000
        && dport_addr[31:28] != 4'h8;
    initial begin
        {imem_ack, imem_rdata, dbus_err} = '0;
    end
    // idle data is inverted so a stale word never passes for a fresh one;
    // answering just after the rising edge keeps clear of bench drives
    always @(posedge clk) begin
        #1;
        phase <= ~phase;
        imem_ack <= hit;
        imem_rdata <= hit ? {imem_addr[15:0], ~imem_addr[15:0]}
            : ~imem_rdata;
        dbus_err <= err_inject && dport_req[1] && periph;
    end
endmodule

// File: verification/tb_core_pipeline_exception_status.sv
// self-checking bench for the pipeline and exception block
`timescale 1ns/100ps
`include "cpe_defines.svh"
module tb_core_pipeline_exception_status;
    logic clk, rst_n, imem_ack, ex_busy, br_taken, br_delay, dreq, slow;
    logic dreq_store, trap_unaligned, dbus_err, exc_illegal, exc_ibus;
    logic exc_div0, exc_fpu, spec_rd, spec_wr, err_inject, imem_req;
    logic dec_valid, ex_valid, dport_we, exc_taken;
    logic [31:0] imem_rdata, imem_addr, dec_pc, ex_instr, ex_pc, p;
    logic [31:0] br_target, dreq_addr, dport_addr, spec_wdata;
    logic [31:0] spec_rdata, exc_ret_pc;
    logic [4:0] dreq_reg, fp_raise;
    logic [3:0] dport_be;
    logic [2:0] dport_req, dport_abort, special_sel;
    logic [1:0] dreq_size;
    // local, peripheral and cache-link targets: lanes with store, aborts
    logic [31:0] ta [3] = '{32'h0000_0100, 32'h4000_0002, 32'h8000_0001};
    logic [31:0] tlane [3] = '{32'h0000_001E, 32'h0000_0007, 32'h0000_0008};
    logic [31:0] tab [3] = '{32'h0000_0006, 32'h0000_0005, 32'h0000_0003};
    int fails = 0;
    int comparisons = 0;
    int n;
    cpe_core_pipe dut (.clk, .rst_n, .imem_rdata, .imem_ack, .imem_req,
        .imem_addr, .dec_valid, .dec_pc, .ex_valid, .ex_instr, .ex_pc,
        .ex_busy, .br_taken, .br_delay, .br_target, .dreq, .dreq_addr,
        .dreq_size, .dreq_store, .dreq_reg, .trap_unaligned, .dport_req,
        .dport_abort, .dport_addr, .dport_be, .dport_we, .dbus_err,
        .exc_illegal, .exc_ibus, .exc_div0, .exc_fpu, .fp_raise, .spec_rd,
        .spec_wr, .special_sel, .spec_wdata, .spec_rdata, .exc_taken,
        .exc_ret_pc);
    cpe_mem_model mem (.clk, .slow, .err_inject, .imem_req, .imem_addr,
        .imem_ack, .imem_rdata, .dport_req, .dport_addr, .dbus_err);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic end_of_test();
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] want,
            input string what);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("mismatch at %0t: %s got %h want %h", $time, what,
                seen, want);
        end
    endtask
    // one special access; its strobe stands until the next call, so
    // no strobe is set twice in one time step
    task automatic sp(input logic w, input logic [2:0] s,
            input logic [31:0] d);
        special_sel = s;
        spec_wdata = d;
        {spec_wr, spec_rd} = {w, !w};
        @(negedge clk);
        if (!w) begin
            chk(spec_rdata, d, "special reg");
        end
    endtask
    // bounded wait, n ends as the number of idle cycles seen
    task automatic wait_ex();
        for (n = 0; ex_valid !== 1'b1; n++) begin
            if (n > 50) begin
                fails++;
                end_of_test();
            end
            @(negedge clk);
        end
    endtask
    initial begin
        {rst_n, ex_busy, br_taken, br_delay, dreq, dreq_store, slow} = '0;
        {exc_illegal, exc_ibus, exc_div0, exc_fpu, spec_rd, spec_wr} = '0;
        {err_inject, br_target, dreq_addr, dreq_reg, fp_raise} = '0;
        {special_sel, dreq_size, spec_wdata} = '0;
        trap_unaligned = 1'b1;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        sp(1'b0, 3'h3, 32'h0000_0000);
        sp(1'b0, 3'h5, 32'h0000_0000);
        sp(1'b0, 3'h7, 32'h0000_0000);
        wait_ex();
        repeat (3) begin
            p = ex_pc + 32'h0000_0004;
            @(negedge clk);
            chk(ex_instr, {p[15:0], ~p[15:0]}, "stream");
        end
        p = ex_pc;
        {ex_busy, slow} = 2'h3;
        repeat (6) @(negedge clk);
        chk(dec_pc, p + 32'h0000_0004, "decode held");
        chk(32'(imem_req), 32'h0000_0000, "buffer full");
        ex_busy = 1'b0;
        // slow memory: held and prefetched words plus one slow fetch keep the stream unbroken
        for (int k = 0; k < 5; k++) begin
            chk(ex_pc, p + 32'(4 * k), "resume");
            @(negedge clk);
        end
        slow = 1'b0;
        wait_ex();
        br_taken = 1'b1;
        br_target = 32'h0000_0400;
        @(negedge clk);
        br_taken = 1'b0;
        chk(32'({dec_valid, ex_valid}), 32'h0000_0000, "flush");
        chk(imem_addr, 32'h0000_0400, "refetch");
        wait_ex();
        chk(32'(n), 32'h0000_0002, "refill");
        chk(ex_pc, 32'h0000_0400, "target");
        p = dec_pc;
        {br_taken, br_delay} = 2'h3;
        br_target = 32'h0000_0800;
        @(negedge clk);
        {br_taken, br_delay} = 2'h0;
        chk(ex_pc, p, "slot kept");
        chk(32'({dec_valid, ex_valid}), 32'h0000_0001, "slot");
        chk(imem_addr, 32'h0000_0800, "slot target");
        @(negedge clk);
        wait_ex();
        chk(32'(n), 32'h0000_0001, "slot penalty");
        chk(ex_pc, 32'h0000_0800, "slot refill");
        $display("test pipeline done");
        for (int i = 0; i < 3; i++) begin
            dreq = 1'b1;
            dreq_addr = ta[i];
            dreq_size = 2'(2 - i);
            dreq_store = (i == 1);
            @(negedge clk);
            dreq = 1'b0;
            chk(32'(dport_req), 32'h0000_0007, "all ports");
            chk(dport_addr, ta[i], "address");
            chk(32'({dport_be, dport_we}), tlane[i], "lanes");
            @(negedge clk);
            chk(32'(dport_abort), tab[i], "abort");
        end
        $display("test data ports done");
        p = dec_pc;
        {dreq, dreq_store, dreq_size} = 4'hE;
        dreq_addr = 32'h0000_0102;
        dreq_reg = 5'h07;
        @(negedge clk);
        dreq = 1'b0;
        chk(32'({exc_taken, ex_valid, dport_req}), 32'h0000_0010, "trap");
        chk(exc_ret_pc, p, "return pc");
        chk(imem_addr, `CPE_EXC_VECTOR, "vector");
        sp(1'b0, 3'h3, 32'h0000_0102);
        sp(1'b0, 3'h5, 32'h0000_0CE1);
        {err_inject, dreq, dreq_store} = 3'h6;
        dreq_addr = 32'h4000_0008;
        @(negedge clk);
        dreq = 1'b0;
        @(negedge clk);
        err_inject = 1'b0;
        chk(32'(exc_taken), 32'h0000_0001, "bus fault");
        sp(1'b0, 3'h3, 32'h4000_0008);
        sp(1'b0, 3'h5, 32'h0000_0004);
        for (int i = 0; i < 4; i++) begin
            {exc_fpu, exc_div0, exc_ibus, exc_illegal} = 4'(1 << i);
            @(negedge clk);
            {exc_fpu, exc_div0, exc_ibus, exc_illegal} = 4'h0;
            sp(1'b0, 3'h5, 32'(i + 2 + (i > 1)));
        end
        $display("test exceptions done");
        sp(1'b1, 3'h7, 32'h0000_0015);
        sp(1'b0, 3'h7, 32'h0000_0015);
        fp_raise = 5'h02;
        @(negedge clk);
        fp_raise = 5'h00;
        sp(1'b0, 3'h7, 32'h0000_0017);
        sp(1'b1, 3'h7, 32'h0000_0000);
        sp(1'b0, 3'h7, 32'h0000_0000);
        sp(1'b1, 3'h5, 32'hFFFF_FFFF);
        sp(1'b0, 3'h5, 32'h0000_0006);
        $display("test fp flags done");
        end_of_test();
    end
endmodule
